// ### core/mnx_pkg.sv
// shared constants and types for the multiply / negate / no-op datapath
package mnx_pkg;
  // instruction field layout
  localparam int MNX_LIT_MSB = 7;
  localparam int MNX_FILE_MSB = 7;
  localparam int MNX_ABIT_POS = 8;
  // opcode patterns on the upper instruction bits
  localparam logic [7:0] MNX_MUL_LIT_CODE = 8'h0D;
  localparam logic [6:0] MNX_MUL_REG_CODE = 7'h01;
  localparam logic [6:0] MNX_NEG_CODE = 7'h36;
  localparam logic [15:0] MNX_NOP_ZERO_CODE = 16'h0000;
  localparam logic [3:0] MNX_NOP_HI_NIBBLE = 4'hF;
  // access bank and indexed offset addressing
  localparam logic [7:0] MNX_IDX_LIMIT = 8'h5F;
  localparam logic [7:0] MNX_ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] MNX_ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] MNX_ACCESS_HI_BANK = 4'hF;
  // reset values
  localparam logic [7:0] MNX_PROD_RESET = 8'h00;
  localparam logic [7:0] MNX_BYTE_ONE = 8'h01;
  localparam logic [11:0] MNX_ADDR_RESET = 12'h000;
  localparam logic [15:0] MNX_IR_RESET = 16'h0000;

  // instruction cycle phases, one-hot
  typedef enum logic [3:0] {
    MNX_Q1 = 4'h1,
    MNX_Q2 = 4'h2,
    MNX_Q3 = 4'h4,
    MNX_Q4 = 4'h8
  } mnx_phase_t;

  // decoded operation, one-hot
  typedef enum logic [3:0] {
    MNX_OP_NONE = 4'h1,
    MNX_OP_MUL_LIT = 4'h2,
    MNX_OP_MUL_REG = 4'h4,
    MNX_OP_NEG = 4'h8
  } mnx_op_t;
endpackage : mnx_pkg

// ### core/mnx_bank_addr.sv
// operand address resolution: access bank, banked file or indexed offset
`timescale 1ns/1ps
`default_nettype none
module mnx_bank_addr
  import mnx_pkg::*;
(
  input wire logic [7:0] file_addr_i,
  input wire logic access_sel_i,
  input wire logic [3:0] bank_select_reg_i,
  input wire logic ext_set_en_i,
  input wire logic [11:0] index_base_i,
  output logic [11:0] data_addr_o
);
  // which of the three address forms applies
  wire use_indexed = ext_set_en_i && !access_sel_i && (file_addr_i <= MNX_IDX_LIMIT);
  wire low_access = file_addr_i < MNX_ACCESS_SPLIT;
  wire [11:0] indexed_addr = index_base_i + {4'h0, file_addr_i}; // wraps in 4 KB space
  wire [11:0] access_addr = low_access ? {MNX_ACCESS_LO_BANK, file_addr_i}
                                       : {MNX_ACCESS_HI_BANK, file_addr_i};
  wire [11:0] banked_addr = {bank_select_reg_i, file_addr_i};

  // indexed form overrides the access bank only for the low window
  assign data_addr_o = access_sel_i ? banked_addr : (use_indexed ? indexed_addr : access_addr);
endmodule : mnx_bank_addr
`default_nettype wire

// ### core/mnx_exec.sv
// execution datapath for literal multiply, register multiply, negate and no-op
// Notes on behaviour
// - literal multiply: working register times low byte
// - literal product high byte, low byte to pair
// - multiplies keep flags and working register
// - multiplies report no carry, overflow, zero
// - register multiply: working register times file
// - register product into pair, sources untouched
// - bank bit low: access bank, high: banked
// - extended set, access, f<=95: indexed offset
// - negate: invert plus one, update five flags
// - negate writes back to its source location
`timescale 1ns/1ps
`default_nettype none
module mnx_exec
  import mnx_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [15:0] instr_i,
  input wire logic [7:0] w_reg_i,
  input wire logic [3:0] bank_select_reg_i,
  input wire logic ext_set_en_i,
  input wire logic [11:0] index_base_i,
  input wire logic [7:0] mem_rdata_i,
  output logic [11:0] mem_addr_o,
  output logic mem_re_o,
  output logic mem_we_o,
  output logic [7:0] mem_wdata_o,
  output logic [7:0] product_high_reg_o,
  output logic [7:0] product_low_reg_o,
  output logic neg_flag_o,
  output logic overflow_flag_o,
  output logic carry_flag_o,
  output logic digit_carry_flag_o,
  output logic zero_flag_o
);
  mnx_phase_t phase;
  mnx_phase_t next_phase;
  mnx_op_t op;
  logic [15:0] ir;

  // decode of the word presented in Q1
  wire is_mul_lit = instr_i[15:8] == MNX_MUL_LIT_CODE;
  wire is_mul_reg = instr_i[15:9] == MNX_MUL_REG_CODE;
  wire is_neg = instr_i[15:9] == MNX_NEG_CODE;
  wire is_nop = (instr_i == MNX_NOP_ZERO_CODE) || (instr_i[15:12] == MNX_NOP_HI_NIBBLE);
  // anything outside this block's four opcodes is treated as a no-op here
  wire mnx_op_t next_op = is_mul_lit ? MNX_OP_MUL_LIT :
                          is_mul_reg ? MNX_OP_MUL_REG :
                          is_neg ? MNX_OP_NEG : MNX_OP_NONE;
  wire needs_file = is_mul_reg || is_neg;
  wire [11:0] next_addr;

  mnx_bank_addr u_bank_addr (
    .file_addr_i(instr_i[MNX_FILE_MSB:0]),
    .access_sel_i(instr_i[MNX_ABIT_POS]),
    .bank_select_reg_i(bank_select_reg_i),
    .ext_set_en_i(ext_set_en_i),
    .index_base_i(index_base_i),
    .data_addr_o(next_addr)
  );

  // arithmetic: both multiplies share one 8x8 unsigned multiplier
  wire [7:0] mul_operand = (op == MNX_OP_MUL_LIT) ? ir[MNX_LIT_MSB:0] : mem_rdata_i;
  wire [15:0] product = w_reg_i * mul_operand;
  wire [7:0] inv_data = ~mem_rdata_i;
  wire [8:0] neg_sum = {1'b0, inv_data} + 9'h001;
  wire [4:0] neg_nib = {1'b0, inv_data[3:0]} + 5'h01;
  wire [7:0] neg_res = neg_sum[7:0];
  // signed overflow only when negating the most negative value
  wire neg_ov = (inv_data[7] == 1'b0) && neg_res[7];
  wire do_mul = (phase == MNX_Q3) && ((op == MNX_OP_MUL_LIT) || (op == MNX_OP_MUL_REG));
  wire do_neg = (phase == MNX_Q3) && (op == MNX_OP_NEG);

  // phase sequencer: one instruction per four clocks
  always_comb begin
    case (phase)
      MNX_Q1: next_phase = MNX_Q2;
      MNX_Q2: next_phase = MNX_Q3;
      MNX_Q3: next_phase = MNX_Q4;
      MNX_Q4: next_phase = MNX_Q1;
      default: next_phase = MNX_Q1;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      phase <= MNX_Q1;
    end else if (ce_i) begin
      phase <= next_phase;
    end
  end

  // decode and operand address latch at the end of Q1
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      ir <= MNX_IR_RESET;
      op <= MNX_OP_NONE;
      mem_addr_o <= MNX_ADDR_RESET;
      mem_re_o <= 1'b0;
    end else if (ce_i) begin
      if (phase == MNX_Q1) begin
        ir <= instr_i;
        op <= next_op;
        mem_addr_o <= next_addr;
        mem_re_o <= needs_file; // read strobe stands during Q2
      end else begin
        mem_re_o <= 1'b0;
      end
    end
  end

  // product pair updates at the end of Q3, seen during Q4
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      product_high_reg_o <= MNX_PROD_RESET;
      product_low_reg_o <= MNX_PROD_RESET;
    end else if (ce_i && do_mul) begin
      product_high_reg_o <= product[15:8];
      product_low_reg_o <= product[7:0];
    end
  end

  // flags move only on negate; multiplies never touch them
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      neg_flag_o <= 1'b0;
      overflow_flag_o <= 1'b0;
      carry_flag_o <= 1'b0;
      digit_carry_flag_o <= 1'b0;
      zero_flag_o <= 1'b0;
    end else if (ce_i && do_neg) begin
      neg_flag_o <= neg_res[7];
      overflow_flag_o <= neg_ov;
      carry_flag_o <= neg_sum[8];
      digit_carry_flag_o <= neg_nib[4];
      zero_flag_o <= neg_res == 8'h00;
    end
  end

  // negate write-back: same address as the read, strobe during Q4
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      mem_we_o <= 1'b0;
      mem_wdata_o <= MNX_PROD_RESET;
    end else if (ce_i) begin
      mem_we_o <= do_neg;
      if (do_neg) begin
        mem_wdata_o <= neg_res;
      end
    end
  end

  // checks
  a_phase_order: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (ce_i && phase == MNX_Q4) |=> (phase == MNX_Q1))
    else $error("phase did not wrap from Q4 to Q1");

  // operands widened first so the product is never cut to eight bits
  a_mul_lit_product: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (ce_i && phase == MNX_Q3 && op == MNX_OP_MUL_LIT) |=>
      ({product_high_reg_o, product_low_reg_o} ==
        (16'($past(w_reg_i)) * 16'($past(ir[7:0])))))
    else $error("literal product wrong");

  a_mul_reg_product: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (ce_i && phase == MNX_Q3 && op == MNX_OP_MUL_REG) |=>
      ({product_high_reg_o, product_low_reg_o} ==
        (16'($past(w_reg_i)) * 16'($past(mem_rdata_i)))) && !mem_we_o)
    else $error("register product wrong or memory written");

  a_mul_no_write: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (ce_i && phase == MNX_Q3 && op != MNX_OP_NEG) |=> !mem_we_o)
    else $error("memory written by an instruction other than negate");

  a_mul_flags_kept: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (ce_i && do_mul) |=> $stable({neg_flag_o, overflow_flag_o, carry_flag_o,
                                  digit_carry_flag_o, zero_flag_o}))
    else $error("multiply changed a flag");

  a_nop_quiet: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (ce_i && phase == MNX_Q3 && op == MNX_OP_NONE) |=>
      $stable({product_high_reg_o, product_low_reg_o, zero_flag_o, carry_flag_o}) && !mem_we_o)
    else $error("no-op changed state");

  a_neg_result: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (ce_i && do_neg) |=> (mem_wdata_o == 8'(8'h00 - $past(mem_rdata_i)))
      && (carry_flag_o == ($past(mem_rdata_i) == 8'h00))
      && (overflow_flag_o == ($past(mem_rdata_i) == 8'h80)))
    else $error("negate result or flags wrong");

  // sign set for inputs 01 to 80, zero only when the input was zero
  a_neg_flags: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (ce_i && do_neg) |=>
      (neg_flag_o == (($past(mem_rdata_i) != 8'h00) && ($past(mem_rdata_i) <= 8'h80)))
      && (zero_flag_o == ($past(mem_rdata_i) == 8'h00))
      && (digit_carry_flag_o == ($past(mem_rdata_i[3:0]) == 4'h0)))
    else $error("negate sign, zero or digit carry flag wrong");

  a_we_single: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (ce_i && mem_we_o) |=> !mem_we_o)
    else $error("write strobe stood longer than one phase");

  a_neg_writeback: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (ce_i && phase == MNX_Q1 && is_neg) ##1 (ce_i [*2]) |=> mem_we_o && $stable(mem_addr_o))
    else $error("negate did not write back to its source");

  a_access_bank: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (ce_i && phase == MNX_Q1 && !instr_i[8] && !ext_set_en_i) |=>
      (mem_addr_o[11:8] == (($past(instr_i[7:0]) < 8'h60) ? 4'h0 : 4'hF)))
    else $error("access bank address wrong");

  a_banked_file: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (ce_i && phase == MNX_Q1 && instr_i[8]) |=>
      (mem_addr_o == {$past(bank_select_reg_i), $past(instr_i[7:0])}))
    else $error("banked address wrong");

  a_indexed_mode: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (ce_i && phase == MNX_Q1 && !instr_i[8] && ext_set_en_i && instr_i[7:0] <= 8'h5F) |=>
      (mem_addr_o == 12'($past(index_base_i) + $past(instr_i[7:0]))))
    else $error("indexed offset address wrong");

  a_read_strobe: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (ce_i && phase == MNX_Q1) |=> (mem_re_o == $past(needs_file)) ##1
      (!mem_re_o || !$past(ce_i)))
    else $error("read strobe wrong");
endmodule : mnx_exec
`default_nettype wire

// ### test/mnx_exec_tb.sv
// self-checking bench for the multiply / negate / no-op datapath
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mnx_pkg::*;
  logic ref_clk_i, rst_b_i, ce_i, ext_set_en_i;
  logic [15:0] instr_i;
  logic [7:0] w_reg_i, mem_rdata_i, mem_wdata_o, prod_hi, prod_lo;
  logic [3:0] bank_select_reg_i;
  logic [11:0] index_base_i, mem_addr_o, seen_addr, seen_addr4;
  logic mem_re_o, mem_we_o, n_f, ov_f, c_f, dc_f, z_f;
  logic seen_re, seen_re3, seen_we, seen_we1;
  logic [7:0] seen_wdata;
  int err_total, compares;
  int cycles = 0;
  wire [4:0] flags = {n_f, ov_f, c_f, dc_f, z_f};

  mnx_exec uut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .instr_i(instr_i),
    .w_reg_i(w_reg_i), .bank_select_reg_i(bank_select_reg_i), .ext_set_en_i(ext_set_en_i),
    .index_base_i(index_base_i), .mem_rdata_i(mem_rdata_i), .mem_addr_o(mem_addr_o),
    .mem_re_o(mem_re_o), .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o),
    .product_high_reg_o(prod_hi), .product_low_reg_o(prod_lo), .neg_flag_o(n_f),
    .overflow_flag_o(ov_f), .carry_flag_o(c_f), .digit_carry_flag_o(dc_f), .zero_flag_o(z_f));

  // 20 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  task automatic print_verdict;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cfg(input logic [3:0] bank, input logic ext, input logic [11:0] base);
    bank_select_reg_i = bank;
    ext_set_en_i = ext;
    index_base_i = base;
  endtask : cfg

  // one instruction, entered and left at the falling edge inside Q1
  task automatic exec(input logic [15:0] ins, input logic [7:0] w, input logic [7:0] rd,
                      input int stall);
    instr_i = ins;
    w_reg_i = w;
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    instr_i = 16'hFFFF;  // word must already be latched, so disturb it
    mem_rdata_i = rd;
    if (stall > 0) begin
      ce_i = 1'b0;
      repeat (stall) @(negedge ref_clk_i);
      ce_i = 1'b1;
    end
    seen_re = mem_re_o;
    seen_addr = mem_addr_o;
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    seen_re3 = mem_re_o;
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    mem_rdata_i = ~rd;  // read data no longer valid
    seen_we = mem_we_o;
    seen_wdata = mem_wdata_o;
    seen_addr4 = mem_addr_o;
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    seen_we1 = mem_we_o;
  endtask : exec

  task automatic chk_strobes(input logic re, input logic we);
    chk({12'h000, seen_re, seen_re3, seen_we, seen_we1}, {12'h000, re, 1'b0, we, 1'b0});
  endtask : chk_strobes

  task automatic do_neg(input logic [15:0] ins, input logic [3:0] bank, input logic ext,
                        input logic [11:0] base, input logic [7:0] d, input logic [11:0] ea);
    logic [7:0] r;
    logic [15:0] prod0;
    r = 8'h00 - d;
    prod0 = {prod_hi, prod_lo};
    cfg(bank, ext, base);
    exec(ins, 8'h5A, d, 0);
    chk({4'h0, seen_addr}, {4'h0, ea});
    chk({4'h0, seen_addr4}, {4'h0, ea});
    chk({8'h00, seen_wdata}, {8'h00, r});
    chk({11'h000, flags}, {11'h000, r[7], d == 8'h80, d == 8'h00, d[3:0] == 4'h0, r == 8'h00});
    chk({prod_hi, prod_lo}, prod0);
    chk_strobes(1'b1, 1'b1);
  endtask : do_neg

  task automatic do_mul(input logic [15:0] ins, input logic [7:0] w, input logic [7:0] d,
                        input logic [3:0] bank, input logic ext, input logic [11:0] base,
                        input logic [11:0] ea, input int stall);
    logic is_reg;
    logic [4:0] f0;
    logic [15:0] p;
    is_reg = (ins[15:9] == 7'h01);
    f0 = flags;
    p = w * (is_reg ? d : ins[7:0]);
    cfg(bank, ext, base);
    exec(ins, w, d, stall);
    chk({prod_hi, prod_lo}, p);
    chk({11'h000, flags}, {11'h000, f0});
    chk_strobes(is_reg, 1'b0);
    if (is_reg) begin
      chk({4'h0, seen_addr}, {4'h0, ea});
    end
  endtask : do_mul

  task automatic do_nops;
    logic [15:0] words [4] = '{16'h0000, 16'hF123, 16'hFFFF, 16'h0E55};
    logic [15:0] p0;
    logic [4:0] f0;
    foreach (words[i]) begin
      p0 = {prod_hi, prod_lo};
      f0 = flags;
      exec(words[i], 8'h77, 8'h80, 0);
      chk({prod_hi, prod_lo}, p0);
      chk({11'h000, flags}, {11'h000, f0});
      chk_strobes(1'b0, 1'b0);
    end
  endtask : do_nops

  // hang guard: the whole run needs well under this many cycles
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 600) begin
      err_total++;
      print_verdict();
    end
  end

  initial begin
    {rst_b_i, ext_set_en_i, bank_select_reg_i, index_base_i} = '0;
    {instr_i, w_reg_i, mem_rdata_i} = '0;
    ce_i = 1'b1;
    err_total = 0;
    compares = 0;
    repeat (2) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    chk({prod_hi, prod_lo}, 16'h0000);
    chk({11'h000, flags}, 16'h0000);
    do_neg(16'h6D3A, 4'h5, 1'b0, 12'h000, 8'h3A, 12'h53A);
    do_neg(16'h6C70, 4'h5, 1'b1, 12'h123, 8'h00, 12'hF70);
    do_neg(16'h6C10, 4'h5, 1'b1, 12'h123, 8'h80, 12'h133);
    do_neg(16'h6C5F, 4'h5, 1'b1, 12'hFF0, 8'h08, 12'h04F);
    do_neg(16'h6C60, 4'h5, 1'b1, 12'h123, 8'hF0, 12'hF60);
    do_neg(16'h6C05, 4'h5, 1'b0, 12'h123, 8'h01, 12'h005);
    do_mul(16'h0DC4, 8'hE2, 8'h33, 4'h0, 1'b0, 12'h000, 12'h000, 0);
    do_neg(16'h6D3A, 4'h5, 1'b0, 12'h000, 8'h3A, 12'h53A);
    do_mul(16'h0D00, 8'hFF, 8'h33, 4'h0, 1'b0, 12'h000, 12'h000, 0);
    do_mul(16'h0DFF, 8'hFF, 8'h00, 4'h0, 1'b0, 12'h000, 12'h000, 3);
    do_mul(16'h0320, 8'hC4, 8'hB5, 4'h2, 1'b0, 12'h000, 12'h220, 0);
    do_mul(16'h0210, 8'h10, 8'h10, 4'h2, 1'b1, 12'h300, 12'h310, 0);
    do_mul(16'h0280, 8'h00, 8'h9C, 4'h2, 1'b0, 12'h300, 12'hF80, 0);
    do_nops();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
